//--- verilog/alpo_top.v
// Absolute linear position output on the divided-pulse lines
//
// Overview of operation
// RQ1: Position is held as a 36-bit signed two's-complement value.
// RQ2: Position counts encoder quadrature edges from the encoder origin.
// RQ3: Report uses the position snapshot taken when the report starts.
// RQ4: Snapshot splits into signed upper 16 bits and lower 20 bits.
// RQ5: Upper part goes first as a serial message on phase A.
// RQ6: Lower 20 bits then follow as a quadrature pulse train.
// RQ7: After the train, phase A and B follow live encoder movement.
// RQ8: No report is produced before control power is up.
// RQ9: A rising report request starts the output sequence.
// RQ10: Host must receive the serial message with its own receiver.
// RQ11: During the serial message phase B stays low and steady.
// RQ12: Usage setting 0 absolute, 1 incremental, latched only at restart.
// RQ13: Limit mismatch alarm raised at restart when the two limits differ.
// RQ14: Serial frame is 9600 baud, start, 7 bits, even parity, stop.
// RQ15: Message is P, sign, five digits, carriage return.
// RQ16: Origin output carries only the encoder origin marker, always.
`include "alpo_regs.vh"

module alpo_top #(
  parameter BAUD_CYCLES = `ALPO_BAUD_CYCLES,
  parameter EDGE_CYCLES = `ALPO_EDGE_CYCLES
) (
  input  wire                      clock,
  input  wire                      rst_b,
  input  wire                      control_power_ok,
  input  wire                      encoder_report_request,
  input  wire                      encoder_usage_setting,
  input  wire [`ALPO_LIMIT_W-1:0]  turn_wrap_limit_setting,
  input  wire [`ALPO_LIMIT_W-1:0]  encoder_turn_wrap_limit,
  input  wire [`ALPO_POS_W-1:0]    encoder_position,
  input  wire                      enc_phase_a,
  input  wire                      enc_phase_b,
  input  wire                      enc_origin,
  output reg                       phase_a_divided_out,
  output reg                       phase_b_divided_out,
  output reg                       origin_marker_out,
  output reg                       limit_mismatch_alarm,
  output reg                       absolute_mode,
  output reg                       report_busy
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CONV  = 3'h1;
  localparam [2:0] ST_SEND  = 3'h2;
  localparam [2:0] ST_WAIT  = 3'h3;
  localparam [2:0] ST_PULSE = 3'h4;
  localparam [2:0] ST_INCR  = 3'h5;

  localparam integer           EDGE_LAST_I = EDGE_CYCLES - 1;
  localparam [`ALPO_CNT_W-1:0] EDGE_LAST   = EDGE_LAST_I[`ALPO_CNT_W-1:0];
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [5:0]                sync_1;
  reg [5:0]                sync_2;
  reg [`ALPO_LIMIT_W-1:0]  drv_limit_1;
  reg [`ALPO_LIMIT_W-1:0]  drv_limit_2;
  reg [`ALPO_LIMIT_W-1:0]  enc_limit_1;
  reg [`ALPO_LIMIT_W-1:0]  enc_limit_2;
  reg [`ALPO_POS_W-1:0]    enc_pos_1;
  reg [`ALPO_POS_W-1:0]    enc_pos_2;

  wire power_ok = sync_2[0];
  wire request  = sync_2[1];
  wire usage    = sync_2[2];
  wire a_now    = sync_2[3];
  wire b_now    = sync_2[4];
  wire z_now    = sync_2[5];

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_1      <= 6'h00;
      sync_2      <= 6'h00;
      drv_limit_1 <= {`ALPO_LIMIT_W{1'b0}};
      drv_limit_2 <= {`ALPO_LIMIT_W{1'b0}};
      enc_limit_1 <= {`ALPO_LIMIT_W{1'b0}};
      enc_limit_2 <= {`ALPO_LIMIT_W{1'b0}};
      enc_pos_1   <= {`ALPO_POS_W{1'b0}};
      enc_pos_2   <= {`ALPO_POS_W{1'b0}};
    end else begin
      sync_1      <= {enc_origin, enc_phase_b, enc_phase_a,
                      encoder_usage_setting, encoder_report_request,
                      control_power_ok};
      sync_2      <= sync_1;
      drv_limit_1 <= turn_wrap_limit_setting;
      drv_limit_2 <= drv_limit_1;
      enc_limit_1 <= encoder_turn_wrap_limit;
      enc_limit_2 <= enc_limit_1;
      enc_pos_1   <= encoder_position;
      enc_pos_2   <= enc_pos_1;
    end
  end

  // ----------------------------------------------------------------
  // Restart capture
  // ----------------------------------------------------------------
  // Settings are sampled once after release; later changes wait for restart
  reg [1:0] boot_count;
  reg       booted;
  wire      boot_capture = !booted && (boot_count == 2'h3);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      boot_count           <= 2'h0;
      booted               <= 1'b0;
      absolute_mode        <= 1'b0;
      limit_mismatch_alarm <= 1'b0;
    end else if (!booted) begin
      boot_count <= boot_count + 1'b1;
      if (boot_capture) begin
        booted               <= 1'b1;
        absolute_mode        <= (usage == `ALPO_USE_ABSOLUTE);   // RQ12
        limit_mismatch_alarm <= (drv_limit_2 != enc_limit_2);    // RQ13
      end
    end
  end

  // ----------------------------------------------------------------
  // Position tracking
  // ----------------------------------------------------------------
  reg                         a_prev;
  reg                         b_prev;
  reg signed [`ALPO_POS_W-1:0] position;

  wire one_edge = (a_now ^ a_prev) ^ (b_now ^ b_prev);
  wire forward  = a_now ^ b_prev;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      a_prev   <= 1'b0;
      b_prev   <= 1'b0;
      position <= {`ALPO_POS_W{1'b0}};
    end else begin
      a_prev <= a_now;
      b_prev <= b_now;
      if (boot_capture) begin
        position <= enc_pos_2;                                   // RQ1
      end else if (booted && one_edge) begin
        if (forward) begin
          position <= position + 1'b1;                           // RQ2
        end else begin
          position <= position - 1'b1;                           // RQ2
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Report sequencer
  // ----------------------------------------------------------------
  reg [2:0]                state;
  reg                      req_prev;
  reg [`ALPO_HI_W-1:0]     snap_hi;
  reg [`ALPO_LO_W-1:0]     snap_lo;
  reg [`ALPO_LO_W-1:0]     edges_sent;
  reg [16:0]               remainder;
  reg [3:0]                digit_acc;
  reg [2:0]                digit_index;
  reg [3:0]                digit [0:4];
  reg [2:0]                char_index;
  reg [`ALPO_CNT_W-1:0]    edge_timer;
  reg [1:0]                quad_step;
  reg                      tx_start;
  reg [`ALPO_CHAR_W-1:0]   tx_char;
  reg [16:0]               weight;
  reg [`ALPO_CHAR_W-1:0]   next_char;

  wire tx_line;
  wire tx_busy;
  wire tx_done;

  wire req_rise = request && !req_prev;

  always @* begin
    case (digit_index)
      3'h0:    weight = 17'h02710;
      3'h1:    weight = 17'h003e8;
      3'h2:    weight = 17'h00064;
      3'h3:    weight = 17'h0000a;
      default: weight = 17'h00001;
    endcase
  end

  // RQ15
  always @* begin
    case (char_index)
      3'h0:    next_char = `ALPO_CH_P;
      3'h1:    next_char = snap_hi[`ALPO_HI_W-1] ? `ALPO_CH_MINUS : `ALPO_CH_PLUS;
      3'h2:    next_char = `ALPO_CH_ZERO + {3'h0, digit[0]};
      3'h3:    next_char = `ALPO_CH_ZERO + {3'h0, digit[1]};
      3'h4:    next_char = `ALPO_CH_ZERO + {3'h0, digit[2]};
      3'h5:    next_char = `ALPO_CH_ZERO + {3'h0, digit[3]};
      3'h6:    next_char = `ALPO_CH_ZERO + {3'h0, digit[4]};
      default: next_char = `ALPO_CH_CR;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      req_prev    <= 1'b0;
      snap_hi     <= {`ALPO_HI_W{1'b0}};
      snap_lo     <= {`ALPO_LO_W{1'b0}};
      edges_sent  <= {`ALPO_LO_W{1'b0}};
      remainder   <= 17'h00000;
      digit_acc   <= 4'h0;
      digit_index <= 3'h0;
      digit[0]    <= 4'h0;
      digit[1]    <= 4'h0;
      digit[2]    <= 4'h0;
      digit[3]    <= 4'h0;
      digit[4]    <= 4'h0;
      char_index  <= 3'h0;
      edge_timer  <= {`ALPO_CNT_W{1'b0}};
      quad_step   <= 2'h1;
      tx_start    <= 1'b0;
      tx_char     <= {`ALPO_CHAR_W{1'b0}};
    end else begin
      req_prev <= request;
      tx_start <= 1'b0;
      if (!request || !power_ok || !absolute_mode) begin
        // Dropping the request aborts any report in progress
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            if (req_rise && booted) begin                        // RQ8 RQ9
              snap_hi     <= position[`ALPO_POS_W-1:`ALPO_LO_W]; // RQ3 RQ4
              snap_lo     <= position[`ALPO_LO_W-1:0];           // RQ4
              remainder   <= position[`ALPO_POS_W-1] ?
                             17'h00000 - {position[`ALPO_POS_W-1], position[`ALPO_POS_W-1:`ALPO_LO_W]} :
                             {1'b0, position[`ALPO_POS_W-1:`ALPO_LO_W]};
              digit_acc   <= 4'h0;
              digit_index <= 3'h0;
              char_index  <= 3'h0;
              state       <= ST_CONV;
            end
          end
          ST_CONV: begin
            // Decimal by repeated subtraction: slow but tiny
            if (remainder >= weight) begin
              remainder <= remainder - weight;
              digit_acc <= digit_acc + 1'b1;
            end else begin
              digit[digit_index] <= digit_acc;
              digit_acc          <= 4'h0;
              if (digit_index == 3'h4) begin
                state <= ST_SEND;
              end else begin
                digit_index <= digit_index + 1'b1;
              end
            end
          end
          ST_SEND: begin
            // An aborted report may leave a character still on the line
            if (!tx_busy) begin
              tx_char  <= next_char;                             // RQ5
              tx_start <= 1'b1;
              state    <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (tx_done) begin
              if (char_index == `ALPO_MSG_LEN - 1) begin
                edges_sent <= {`ALPO_LO_W{1'b0}};
                edge_timer <= {`ALPO_CNT_W{1'b0}};
                quad_step  <= 2'h1;
                state      <= ST_PULSE;                          // RQ6
              end else begin
                char_index <= char_index + 1'b1;
                state      <= ST_SEND;
              end
            end
          end
          ST_PULSE: begin
            if (edges_sent == snap_lo) begin
              state <= ST_INCR;                                  // RQ7
            end else if (edge_timer != EDGE_LAST) begin
              edge_timer <= edge_timer + 1'b1;
            end else begin
              edge_timer <= {`ALPO_CNT_W{1'b0}};
              quad_step  <= quad_step + 1'b1;                    // RQ6
              edges_sent <= edges_sent + 1'b1;
            end
          end
          ST_INCR: state <= ST_INCR;
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // RQ14
  alpo_uart_tx #(
    .BIT_CYCLES (BAUD_CYCLES)
  ) u_uart (
    .clock (clock),
    .rst_b (rst_b),
    .start (tx_start),
    .data  (tx_char),
    .tx    (tx_line),
    .busy  (tx_busy),
    .done  (tx_done)
  );

  // ----------------------------------------------------------------
  // Output lines
  // ----------------------------------------------------------------
  // Absolute-mode idle and pre-capture hold A at mark, B low: no false start bit, no count
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_a_divided_out <= 1'b1;
      phase_b_divided_out <= 1'b0;
      origin_marker_out   <= 1'b0;
      report_busy         <= 1'b0;
    end else begin
      origin_marker_out <= z_now;                                // RQ16
      report_busy       <= (state != ST_IDLE) && (state != ST_INCR);
      if ((booted && !absolute_mode) || state == ST_INCR) begin
        phase_a_divided_out <= a_now;                            // RQ7
        phase_b_divided_out <= b_now;                            // RQ7
      end else if (state == ST_PULSE) begin
        phase_a_divided_out <= quad_step[0] ^ quad_step[1];
        phase_b_divided_out <= quad_step[1];
      end else if (state == ST_SEND || state == ST_WAIT) begin
        phase_a_divided_out <= tx_line;                          // RQ5
        phase_b_divided_out <= 1'b0;                             // RQ11
      end else begin
        phase_a_divided_out <= 1'b1;
        phase_b_divided_out <= 1'b0;                             // RQ11
      end
    end
  end

endmodule

//--- verilog/alpo_regs.vh
// Constants for the absolute linear position output block
`ifndef ALPO_REGS_VH
`define ALPO_REGS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define ALPO_CLK_HZ        40000000
`define ALPO_CLK_MHZ       40
`define ALPO_BAUD_BPS      9600
`define ALPO_BAUD_CYCLES   ((`ALPO_CLK_HZ + `ALPO_BAUD_BPS / 2) / `ALPO_BAUD_BPS)
`define ALPO_EDGE_NS       1000
`define ALPO_EDGE_CYCLES   ((`ALPO_EDGE_NS * `ALPO_CLK_MHZ) / 1000)
`define ALPO_CNT_W         16

// ----------------------------------------------------------------
// Position layout
// ----------------------------------------------------------------
`define ALPO_POS_W         36
`define ALPO_HI_W          16
`define ALPO_LO_W          20
`define ALPO_LIMIT_W       16

// ----------------------------------------------------------------
// Serial character format
// ----------------------------------------------------------------
`define ALPO_CHAR_W        7
`define ALPO_MSG_LEN       8
`define ALPO_CH_P          7'h50
`define ALPO_CH_PLUS       7'h2b
`define ALPO_CH_MINUS      7'h2d
`define ALPO_CH_ZERO       7'h30
`define ALPO_CH_CR         7'h0d

// ----------------------------------------------------------------
// Encoder usage setting values
// ----------------------------------------------------------------
`define ALPO_USE_ABSOLUTE  1'b0
`define ALPO_USE_INCREMENT 1'b1

`endif

//--- verilog/alpo_uart_tx.v
// Start-stop character transmitter, 7 data bits, even parity, one stop bit
`include "alpo_regs.vh"

module alpo_uart_tx #(
  parameter BIT_CYCLES = `ALPO_BAUD_CYCLES
) (
  input  wire                     clock,
  input  wire                     rst_b,
  input  wire                     start,
  input  wire [`ALPO_CHAR_W-1:0]  data,
  output reg                      tx,
  output reg                      busy,
  output reg                      done
);

  localparam integer           BIT_LAST_I = BIT_CYCLES - 1;
  localparam [`ALPO_CNT_W-1:0] BIT_LAST   = BIT_LAST_I[`ALPO_CNT_W-1:0];

  reg [`ALPO_CNT_W-1:0] bit_timer;
  reg [3:0]             bit_index;
  reg [9:0]             frame;

  // ----------------------------------------------------------------
  // Frame: start, data LSB first, even parity, stop
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx        <= 1'b1;
      busy      <= 1'b0;
      done      <= 1'b0;
      bit_timer <= {`ALPO_CNT_W{1'b0}};
      bit_index <= 4'h0;
      frame     <= 10'h3ff;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        tx <= 1'b1;
        if (start) begin
          frame     <= {1'b1, ^data, data, 1'b0};
          tx        <= 1'b0;
          busy      <= 1'b1;
          bit_timer <= {`ALPO_CNT_W{1'b0}};
          bit_index <= 4'h0;
        end
      end else if (bit_timer != BIT_LAST) begin
        bit_timer <= bit_timer + 1'b1;
      end else begin
        bit_timer <= {`ALPO_CNT_W{1'b0}};
        if (bit_index == 4'h9) begin
          busy <= 1'b0;
          done <= 1'b1;
          tx   <= 1'b1;
        end else begin
          bit_index <= bit_index + 1'b1;
          tx        <= frame[bit_index + 4'h1];
        end
      end
    end
  end

endmodule

//--- dv/alpo_checker.sv
// Port-level checker for the position output block
`include "alpo_regs.vh"

module alpo_checker #(
  parameter BAUD_CYCLES = 8,
  parameter EDGE_CYCLES = 2
) (
  input logic                     clock,
  input logic                     rst_b,
  input logic                     control_power_ok,
  input logic                     encoder_report_request,
  input logic                     encoder_usage_setting,
  input logic [`ALPO_LIMIT_W-1:0] turn_wrap_limit_setting,
  input logic [`ALPO_LIMIT_W-1:0] encoder_turn_wrap_limit,
  input logic [`ALPO_POS_W-1:0]   encoder_position,
  input logic                     enc_phase_a,
  input logic                     enc_phase_b,
  input logic                     enc_origin,
  input logic                     phase_a_divided_out,
  input logic                     phase_b_divided_out,
  input logic                     origin_marker_out,
  input logic                     limit_mismatch_alarm,
  input logic                     absolute_mode,
  input logic                     report_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Saturating age since reset, keeps $past clear of reset values
  logic [3:0] up_cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) up_cnt <= 4'h0;
    else if (up_cnt != 4'hf) up_cnt <= up_cnt + 4'h1;
  end

  sequence s_report_start;
    $rose(report_busy);
  endsequence
  sequence s_req_rise;
    $rose(encoder_report_request) && control_power_ok && absolute_mode && !report_busy && up_cnt == 4'hf;
  endsequence

  chk_origin_delay: assert property ((up_cnt > 4'h4) |-> origin_marker_out == $past(enc_origin, 3))
    else $error("origin output not a 3 clock copy of encoder origin");
  chk_incr_mirror: assert property ((up_cnt > 4'h8 && !absolute_mode) |->
      {phase_a_divided_out, phase_b_divided_out} == $past({enc_phase_a, enc_phase_b}, 3))
    else $error("incremental outputs do not follow encoder");
  chk_mode_frozen: assert property ((up_cnt == 4'hf) |-> $stable(absolute_mode) && $stable(limit_mismatch_alarm))
    else $error("mode or alarm changed without restart");
  chk_start_abs: assert property (s_report_start |-> absolute_mode)
    else $error("report started in incremental mode");
  chk_msg_b_low: assert property (s_report_start |-> !phase_b_divided_out [*8])
    else $error("phase b moved at start of message");
  chk_req_busy: assert property (s_req_rise |-> ##[2:8] report_busy)
    else $error("request did not start a report");
  chk_abort_power: assert property ((!control_power_ok) [*4] |=> !report_busy)
    else $error("report runs without control power");
  chk_abort_req: assert property ((!encoder_report_request) [*5] |=> !report_busy)
    else $error("report runs without request");
  chk_idle_lines: assert property ((absolute_mode && !encoder_report_request) [*6] |=>
      phase_a_divided_out && !phase_b_divided_out)
    else $error("idle lines not a high b low");
endmodule

bind alpo_top alpo_checker #(.BAUD_CYCLES(BAUD_CYCLES), .EDGE_CYCLES(EDGE_CYCLES)) u_chk (.*);

//--- dv/alpo_host_model.sv
// Host model: serial receiver on phase A and quadrature counter
module alpo_host_model #(
  parameter BIT_CYCLES = 8
) (
  input logic clock,
  input logic rst_b,
  input logic line_a,
  input logic line_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] msg [8];
  logic [8:0] fr;
  int         nchar;
  int         ferr;
  int         bmsg;
  int         qcnt;
  logic       pa;
  logic       pb;

  // Receiver stops after eight characters; later A edges are pulses
  always begin
    @(posedge clock);
    if (!rst_b) begin
      nchar = 0;
      ferr = 0;
    end else if (nchar < 8 && !line_a) begin
      repeat (BIT_CYCLES / 2) @(posedge clock);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES) @(posedge clock);
        fr[i] = line_a;
      end
      if ((^fr[7:0]) || !fr[8]) ferr++;
      msg[nchar] = fr[6:0];
      nchar++;
    end
  end

  // Single-line changes count; A ahead of B counts up
  always @(posedge clock) begin
    if (!rst_b) begin
      bmsg = 0;
      qcnt = 0;
    end else if ((line_a != pa) ^ (line_b != pb)) begin
      if (nchar < 8 && line_b != pb) bmsg++;
      if (nchar == 8) qcnt += (line_a ^ pb) ? 1 : -1;
    end
    pa = line_a;
    pb = line_b;
  end
endmodule

//--- dv/test_absolute_linear_position_output.sv
// Self-checking bench for the position output block
module test_absolute_linear_position_output;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        control_power_ok = 1'b1;
  logic        encoder_report_request = 1'b0;
  logic        encoder_usage_setting = 1'b0;
  logic [15:0] turn_wrap_limit_setting = 16'hffff;
  logic [15:0] encoder_turn_wrap_limit = 16'hffff;
  logic [35:0] encoder_position = 36'h0;
  logic        enc_phase_a = 1'b1;
  logic        enc_phase_b = 1'b0;
  logic        enc_origin = 1'b0;
  logic        pa_out, pb_out, origin_out, alarm, abs_mode, busy;
  logic [1:0]  gray [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  int          eidx = 0;
  int          miscompares = 0;
  int          checked = 0;

  always #12.5 clock = ~clock;

  alpo_top #(.BAUD_CYCLES(8), .EDGE_CYCLES(2)) dut (.clock(clock), .rst_b(rst_b),
    .control_power_ok(control_power_ok), .encoder_report_request(encoder_report_request),
    .encoder_usage_setting(encoder_usage_setting), .turn_wrap_limit_setting(turn_wrap_limit_setting),
    .encoder_turn_wrap_limit(encoder_turn_wrap_limit), .encoder_position(encoder_position),
    .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b), .enc_origin(enc_origin),
    .phase_a_divided_out(pa_out), .phase_b_divided_out(pb_out), .origin_marker_out(origin_out),
    .limit_mismatch_alarm(alarm), .absolute_mode(abs_mode), .report_busy(busy));
  alpo_host_model #(.BIT_CYCLES(8)) host (.clock(clock), .rst_b(rst_b), .line_a(pa_out), .line_b(pb_out));

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic restart(input logic incr, input logic [15:0] lim, input logic [35:0] pos);
    @(posedge clock);
    rst_b <= 1'b0;
    encoder_usage_setting <= incr;
    encoder_turn_wrap_limit <= lim;
    encoder_position <= pos;
    encoder_report_request <= 1'b0;
    {enc_phase_a, enc_phase_b} <= gray[0];
    eidx = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (12) @(posedge clock);
  endtask

  task automatic step_fwd(input int n);
    repeat (n) begin
      eidx = (eidx + 1) % 4;
      {enc_phase_a, enc_phase_b} <= gray[eidx];
      repeat (3) @(posedge clock);
    end
  endtask

  task automatic wait_busy(input logic val);
    for (int n = 0; n < 2000 && busy !== val; n++) @(posedge clock);
    check(36'(busy), 36'(val));
  endtask

  task automatic t_reset_values();
    repeat (4) @(posedge clock);
    check(36'({pa_out, pb_out, origin_out, alarm, abs_mode, busy}), 36'h20);
  endtask

  // Full report: message, pulse train, then live pulses
  task automatic t_report(input logic [35:0] pos);
    int s;
    int mag;
    logic [6:0] exp [8];
    restart(1'b0, 16'hffff, pos);
    check(36'({alarm, abs_mode}), 36'h1);
    encoder_report_request <= 1'b1;
    wait_busy(1'b1);
    enc_origin <= 1'b1;
    @(posedge clock);
    enc_origin <= 1'b0;
    wait_busy(1'b0);
    s = $signed(pos[35:20]);
    mag = s < 0 ? -s : s;
    exp[0] = 7'h50;
    exp[1] = s < 0 ? 7'h2d : 7'h2b;
    for (int i = 0; i < 5; i++) begin
      exp[6 - i] = 7'h30 + 7'(mag % 10);
      mag = mag / 10;
    end
    exp[7] = 7'h0d;
    for (int i = 0; i < 8; i++) check(36'(host.msg[i]), 36'(exp[i]));
    check(36'(host.ferr), 36'h0);
    check(36'(host.bmsg), 36'h0);
    check(36'(host.qcnt), 36'(pos[19:0]));
    step_fwd(3);
    repeat (3) @(posedge clock);
    check(36'(host.qcnt), 36'(pos[19:0]) + 36'h3);
    encoder_report_request <= 1'b0;
    repeat (10) @(posedge clock);
  endtask

  // Incremental use with differing limits
  task automatic t_incremental();
    restart(1'b1, 16'h0063, 36'h0);
    check(36'({alarm, abs_mode}), 36'h2);
    encoder_report_request <= 1'b1;
    repeat (20) @(posedge clock);
    check(36'(busy), 36'h0);
    step_fwd(2);
    repeat (2) @(posedge clock);
    check(36'({pa_out, pb_out}), 36'(gray[2]));
    encoder_report_request <= 1'b0;
  endtask

  // Refused without power, then abort mid-message
  task automatic t_power_abort();
    restart(1'b0, 16'hffff, 36'h0);
    control_power_ok <= 1'b0;
    repeat (4) @(posedge clock);
    encoder_report_request <= 1'b1;
    repeat (20) @(posedge clock);
    check(36'({busy, 7'(host.nchar)}), 36'h0);
    encoder_report_request <= 1'b0;
    control_power_ok <= 1'b1;
    repeat (10) @(posedge clock);
    encoder_report_request <= 1'b1;
    wait_busy(1'b1);
    repeat (100) @(posedge clock);
    encoder_report_request <= 1'b0;
    repeat (8) @(posedge clock);
    check(36'({busy, pa_out, pb_out}), 36'h2);
  endtask

  initial begin
    t_reset_values();
    t_report({16'h7fff, 20'h00008});
    t_report({16'h8000, 20'h00000});
    t_report({16'hffff, 20'h00004});
    t_incremental();
    t_power_abort();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_sim();
  end
endmodule
